// ### design/psl_pin_select.sv
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Lock set freezes all selector values
// - Lock clear lets software change selectors
// - Lock register bits 7..1 read zero
// - Lock flag read/write, zero after any reset
// - Selectors hold 5-bit field, upper bits zero
// - One-shot config: lock cannot be cleared again
// - Power-on restores selections, other resets keep them
// - Selectors always readable, locked or not
module psl_pin_select #(
   parameter logic [psl_pkg::N_IN_SEL*psl_pkg::FIELD_W-1:0] IN_SEL_DEFAULT = '0
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_por,
   // Configuration
   input wire logic i_one_shot_lock_config,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [psl_pkg::ADR_W-1:0] i_wb_adr,
   input wire logic [psl_pkg::SEL_W-1:0] i_wb_sel,
   input wire logic [psl_pkg::DAT_W-1:0] i_wb_dat,
   output logic [psl_pkg::DAT_W-1:0] o_wb_dat,
   output logic o_wb_ack,
   // Crossbar selections
   output logic [psl_pkg::N_IN_SEL*psl_pkg::FIELD_W-1:0] o_in_sel,
   output logic [psl_pkg::N_OUT_SEL*psl_pkg::FIELD_W-1:0] o_out_sel,
   output logic o_selection_lock_flag
);
   import psl_pkg::*;

   // Storage
   logic [FIELD_W-1:0] in_sel_reg [N_IN_SEL];   // Peripheral input selectors
   logic [FIELD_W-1:0] out_sel_reg [N_OUT_SEL]; // Pin output selectors
   logic lock_reg;                              // Selection lock flag
   logic lock_next;                             // Flag value after a lock write
   psl_key_t key_reg;                           // Key sequence progress
   psl_key_t key_next;

   // Bus handshake
   logic ack_reg;                               // Registered acknowledge
   logic [DAT_W-1:0] rdat_reg;                  // Registered read data
   logic [DAT_W-1:0] rdat_next;
   logic req;                                   // New request this cycle
   logic wr;                                    // Write taken this cycle

   // Address decode
   logic hit_lock;
   logic hit_in;
   logic hit_out;
   logic [ADR_W-1:0] in_off;
   logic [ADR_W-1:0] out_off;
   logic [IN_IDX_W-1:0] in_idx;
   logic [OUT_IDX_W-1:0] out_idx;
   logic lane0_wr;                              // Write enabled on the data lane

   // One request per bus cycle; ack low for a cycle between requests
   assign req = i_wb_cyc && i_wb_stb && !ack_reg;
   assign wr = req && i_wb_we;
   assign lane0_wr = wr && i_wb_sel[LANE0];

   // Offsets from each selector block base
   assign in_off = i_wb_adr - IN_BASE_ADR;
   assign out_off = i_wb_adr - OUT_BASE_ADR;
   assign in_idx = in_off[IN_IDX_W+WORD_SHIFT-1:WORD_SHIFT];
   assign out_idx = out_off[OUT_IDX_W+WORD_SHIFT-1:WORD_SHIFT];

   // Decode priority: lock, input block, output block, else unmapped
   always_comb
   begin
      hit_lock = 1'b0;
      hit_in = 1'b0;
      hit_out = 1'b0;
      if (i_wb_adr[WORD_SHIFT-1:0] != WORD_ALIGN)
      begin
         // Misaligned addresses are treated as unmapped
         hit_lock = 1'b0;
      end
      else if (i_wb_adr == LOCK_ADR)
      begin
         hit_lock = 1'b1;
      end
      else if (i_wb_adr >= IN_BASE_ADR &&
               in_off < ADR_W'(N_IN_SEL << WORD_SHIFT))
      begin
         hit_in = 1'b1;
      end
      else if (i_wb_adr >= OUT_BASE_ADR &&
               out_off < ADR_W'(N_OUT_SEL << WORD_SHIFT))
      begin
         hit_out = 1'b1;
      end
   end

   // Key sequence and new lock value
   always_comb
   begin
      key_next = key_reg;
      lock_next = lock_reg;
      if (wr)
      begin
         if (!hit_lock || !i_wb_sel[LANE0])
         begin
            // Any other write breaks the sequence
            key_next = PSL_KEY_IDLE;
         end
         else
         begin
            case (key_reg)
               PSL_KEY_IDLE:
               begin
                  key_next = (i_wb_dat[REG_W-1:0] == KEY_FIRST) ?
                             PSL_KEY_GOT_FIRST : PSL_KEY_IDLE;
               end
               PSL_KEY_GOT_FIRST:
               begin
                  // Only the second key right after the first opens it
                  key_next = (i_wb_dat[REG_W-1:0] == KEY_SECOND) ?
                             PSL_KEY_OPEN : PSL_KEY_IDLE;
               end
               PSL_KEY_OPEN:
               begin
                  // One lock update per sequence, then relock the key
                  key_next = PSL_KEY_IDLE;
                  lock_next = i_wb_dat[LOCK_BIT];
                  // One-shot mode: once set it stays until reset
                  if (i_one_shot_lock_config && lock_reg)
                  begin
                     lock_next = 1'b1;
                  end
               end
               default:
               begin
                  key_next = PSL_KEY_IDLE;
               end
            endcase
         end
      end
   end

   // Lock flag and key state; every reset clears both
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         lock_reg <= LOCK_RESET;
         key_reg <= PSL_KEY_IDLE;
      end
      else
      begin
         lock_reg <= lock_next;
         key_reg <= key_next;
      end
   end

   // Input selectors; only power-on restores defaults, warm resets keep them
   always_ff @(posedge i_clk)
   begin
      for (int i = 0; i < N_IN_SEL; i++)
      begin
         if (i_srst)
         begin
            if (i_por)
            begin
               in_sel_reg[i] <= IN_SEL_DEFAULT[i*FIELD_W +: FIELD_W];
            end
         end
         else if (lane0_wr && hit_in && !lock_reg && in_idx == IN_IDX_W'(i))
         begin
            // Locked writes fall through here and are dropped quietly
            in_sel_reg[i] <= i_wb_dat[FIELD_W-1:0];
         end
      end
   end

   // Output selectors; same lock and reset treatment as the inputs
   always_ff @(posedge i_clk)
   begin
      for (int i = 0; i < N_OUT_SEL; i++)
      begin
         if (i_srst)
         begin
            if (i_por)
            begin
               out_sel_reg[i] <= OUT_SEL_RESET;
            end
         end
         else if (lane0_wr && hit_out && !lock_reg && out_idx == OUT_IDX_W'(i))
         begin
            out_sel_reg[i] <= i_wb_dat[FIELD_W-1:0];
         end
      end
   end

   // Read mux; no gating by the lock so readback is always possible
   always_comb
   begin
      rdat_next = READ_ZERO;
      if (hit_lock)
      begin
         // Bits above the flag are unimplemented
         rdat_next[LOCK_BIT] = lock_reg;
      end
      else if (hit_in)
      begin
         rdat_next[FIELD_W-1:0] = in_sel_reg[in_idx];
      end
      else if (hit_out)
      begin
         rdat_next[FIELD_W-1:0] = out_sel_reg[out_idx];
      end
   end

   // Acknowledge one cycle after the request, drop it the cycle after
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= READ_ZERO;
      end
      else
      begin
         ack_reg <= req;
         if (req && !i_wb_we)
         begin
            rdat_reg <= rdat_next;
         end
      end
   end

   // Port drive
   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;
   assign o_selection_lock_flag = lock_reg;

   // Flatten selector arrays onto the crossbar ports
   always_comb
   begin
      for (int i = 0; i < N_IN_SEL; i++)
      begin
         o_in_sel[i*FIELD_W +: FIELD_W] = in_sel_reg[i];
      end
      for (int i = 0; i < N_OUT_SEL; i++)
      begin
         o_out_sel[i*FIELD_W +: FIELD_W] = out_sel_reg[i];
      end
   end

   // Helper state seen only by the checks below
   logic chk_rd_lock_reg;                       // Answer pending is a lock read
   logic chk_rd_sel_reg;                        // Answer pending is a selector read
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         chk_rd_lock_reg <= 1'b0;
         chk_rd_sel_reg <= 1'b0;
      end
      else
      begin
         chk_rd_lock_reg <= req && !i_wb_we && hit_lock;
         chk_rd_sel_reg <= req && !i_wb_we && (hit_in || hit_out);
      end
   end

   // Locked: inputs frozen across any cycle without reset
   AST_LOCK_FREEZES_IN: assert property (
      @(posedge i_clk) disable iff (i_srst)
      lock_reg |=> $stable(o_in_sel))
      else $error("input selector changed while locked");

   // Locked: outputs frozen likewise
   AST_LOCK_FREEZES_OUT: assert property (
      @(posedge i_clk) disable iff (i_srst)
      lock_reg |=> $stable(o_out_sel))
      else $error("output selector changed while locked");

   // Unlocked write lands in the addressed input selector
   AST_UNLOCKED_WRITE_IN: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (lane0_wr && hit_in && !lock_reg) |=>
      in_sel_reg[$past(in_idx)] == $past(i_wb_dat[FIELD_W-1:0]))
      else $error("unlocked input selector write lost");

   // Unlocked write lands in the addressed output selector
   AST_UNLOCKED_WRITE_OUT: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (lane0_wr && hit_out && !lock_reg) |=>
      out_sel_reg[$past(out_idx)] == $past(i_wb_dat[FIELD_W-1:0]))
      else $error("unlocked output selector write lost");

   // Lock readback shows only the flag
   AST_LOCK_UPPER_ZERO: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (o_wb_ack && chk_rd_lock_reg) |-> o_wb_dat[DAT_W-1:1] == '0)
      else $error("lock register upper bits not zero");

   // Any reset leaves the lock flag clear
   AST_RESET_CLEARS_LOCK: assert property (
      @(posedge i_clk)
      i_srst |=> !o_selection_lock_flag)
      else $error("lock flag set after reset");

   // Selector readback confined to the 5-bit field
   AST_SEL_UPPER_ZERO: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (o_wb_ack && chk_rd_sel_reg) |-> o_wb_dat[DAT_W-1:FIELD_W] == '0)
      else $error("selector upper bits not zero");

   // Flag moves only on a lock write taken from the open key state
   AST_FLAG_NEEDS_KEY: assert property (
      @(posedge i_clk) disable iff (i_srst)
      $changed(lock_reg) |->
      ($past(key_reg) == PSL_KEY_OPEN && $past(wr && hit_lock)))
      else $error("lock flag changed without key sequence");

   // Lock readback carries the flag as it stood when the read was taken
   AST_LOCK_READBACK: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (o_wb_ack && chk_rd_lock_reg) |-> o_wb_dat[LOCK_BIT] == $past(lock_reg))
      else $error("lock register readback differs from flag");

   // Locked writes still complete, so software sees no error
   AST_LOCKED_WRITE_ACKED: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (wr && lock_reg) |=> o_wb_ack)
      else $error("locked write not acknowledged");

   // One-shot mode: a set flag never clears before reset
   AST_ONE_SHOT_STICKS: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (i_one_shot_lock_config && lock_reg) |=> lock_reg)
      else $error("one-shot lock cleared");

   // Power-on restores input and output defaults
   AST_POR_DEFAULTS: assert property (
      @(posedge i_clk)
      (i_srst && i_por) |=>
      o_out_sel == {N_OUT_SEL{OUT_SEL_RESET}} && o_in_sel == IN_SEL_DEFAULT)
      else $error("power-on did not restore selections");

   // Warm reset keeps selections
   AST_WARM_KEEPS: assert property (
      @(posedge i_clk)
      (i_srst && !i_por) |=> $stable(o_out_sel) && $stable(o_in_sel))
      else $error("warm reset changed selections");

   // Reads answer in one cycle whatever the lock
   AST_READ_ANSWERS: assert property (
      @(posedge i_clk) disable iff (i_srst)
      (req && !i_wb_we) |=> o_wb_ack ##1 !o_wb_ack)
      else $error("read not answered in one cycle");

   // Main scenarios
   COV_LOCK_SET: cover property (
      @(posedge i_clk) disable iff (i_srst) !lock_reg ##1 lock_reg);
   COV_LOCKED_WRITE: cover property (
      @(posedge i_clk) disable iff (i_srst) lane0_wr && hit_out && lock_reg);
   COV_UNLOCK: cover property (
      @(posedge i_clk) disable iff (i_srst) lock_reg ##1 !lock_reg);
   // Selector write with the data lane disabled, which must be ignored
   COV_LANE_SKIPPED: cover property (
      @(posedge i_clk) disable iff (i_srst) wr && hit_out && !i_wb_sel[LANE0]);
   COV_ONE_SHOT_REFUSE: cover property (
      @(posedge i_clk) disable iff (i_srst)
      key_reg == PSL_KEY_OPEN && wr && hit_lock && !i_wb_dat[LOCK_BIT] &&
      lock_reg && i_one_shot_lock_config);

endmodule

// ### include/psl_pkg.sv
// Shared constants for the pin select lock and map block
package psl_pkg;

   // Bus geometry
   localparam int ADR_W = 12;               // Byte address width
   localparam int DAT_W = 32;               // Wishbone data width
   localparam int SEL_W = 4;                // Byte select width

   // Selector geometry
   localparam int FIELD_W = 5;              // Selection field, bits 4..0
   localparam int REG_W = 8;                // Architectural register width
   localparam int N_IN_SEL = 28;            // Peripheral input selectors
   localparam int N_OUT_SEL = 17;           // Pin output selectors
   localparam int IN_IDX_W = 5;             // Index width, input selectors
   localparam int OUT_IDX_W = 5;            // Index width, output selectors

   // Register map, byte addresses of word-aligned registers
   localparam logic [ADR_W-1:0] LOCK_ADR = 12'h000;     // Selection lock register
   localparam logic [ADR_W-1:0] IN_BASE_ADR = 12'h040;  // First input selector
   localparam logic [ADR_W-1:0] OUT_BASE_ADR = 12'h100; // First output selector
   localparam int WORD_SHIFT = 2;           // Byte address to word index
   localparam logic [1:0] WORD_ALIGN = 2'h0; // Low address bits of a word

   // Lock register layout
   localparam int LOCK_BIT = 0;             // Lock flag position
   localparam logic LOCK_RESET = 1'b0;      // Lock flag after any reset
   localparam int LANE0 = 0;                // Byte lane holding all data

   // Key sequence values
   localparam logic [REG_W-1:0] KEY_FIRST = 8'h55;
   localparam logic [REG_W-1:0] KEY_SECOND = 8'hAA;

   // Output selector default after power-on
   localparam logic [FIELD_W-1:0] OUT_SEL_RESET = 5'h00;

   // Read value of unmapped space and reserved bits
   localparam logic [DAT_W-1:0] READ_ZERO = 32'h0000_0000;

   // Key sequence progress
   typedef enum logic [1:0]
   {
      PSL_KEY_IDLE = 2'b00,                 // No key seen
      PSL_KEY_GOT_FIRST = 2'b01,            // First key value written
      PSL_KEY_OPEN = 2'b10                  // Next lock write may change the flag
   } psl_key_t;

endpackage

// ### testbench/pin_select_lock_and_map_tb.sv
`timescale 1ns/1ps
module pin_select_lock_and_map_tb;
   import psl_pkg::*;
   // Input selector defaults differ from zero so a design ignoring them shows up
   localparam logic [N_IN_SEL*FIELD_W-1:0] IN_DEF = {28{5'h13}};
   logic i_clk = 1'b0; // Bench clock, 25 MHz
   logic i_srst = 1'b1; // Synchronous reset
   logic i_por = 1'b1; // Power-on qualifier
   logic i_one_shot_lock_config = 1'b0; // One-shot lock configuration
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic [ADR_W-1:0] i_wb_adr = '0;
   logic [SEL_W-1:0] i_wb_sel = '0;
   logic [DAT_W-1:0] i_wb_dat = '0;
   logic [DAT_W-1:0] o_wb_dat;
   logic o_wb_ack;
   logic [N_IN_SEL*FIELD_W-1:0] o_in_sel;
   logic [N_OUT_SEL*FIELD_W-1:0] o_out_sel;
   logic o_selection_lock_flag;
   logic [FIELD_W-1:0] exp_in [N_IN_SEL]; // Expected input selections
   logic [FIELD_W-1:0] exp_out [N_OUT_SEL]; // Expected output selections
   logic exp_lock; // Expected lock flag
   logic [DAT_W-1:0] q; // Last read data
   int n_errors = 0;
   int samples_checked = 0;

   // Device under test
   psl_pin_select #(.IN_SEL_DEFAULT(IN_DEF)) u_dut (.i_clk(i_clk), .i_srst(i_srst),
      .i_por(i_por), .i_one_shot_lock_config(i_one_shot_lock_config), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_in_sel(o_in_sel),
      .o_out_sel(o_out_sel), .o_selection_lock_flag(o_selection_lock_flag));

   // Half period of 20 ns
   always #20 i_clk = ~i_clk;

   // Verdict, the single exit of the run
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Compare one value, four-state exact
   task automatic chk(input string nm, input logic [DAT_W-1:0] e, input logic [DAT_W-1:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   // One classic Wishbone cycle; held until ack is sampled, then released
   // A hang is left to the watchdog, which fails the run
   task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [7:0] d,
                     output logic [DAT_W-1:0] rd, input logic [SEL_W-1:0] s = 4'hF);
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_sel <= s;
      i_wb_dat <= {24'h000000, d};
      do
      begin
         @(posedge i_clk);
      end
      while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
   endtask

   function automatic logic [ADR_W-1:0] in_adr(input int i);
      return IN_BASE_ADR + ADR_W'(i * 4);
   endfunction

   function automatic logic [ADR_W-1:0] out_adr(input int i);
      return OUT_BASE_ADR + ADR_W'(i * 4);
   endfunction

   // Reset for three cycles; power-on also restores the selections
   task automatic rst(input logic por);
      @(posedge i_clk);
      i_srst <= 1'b1;
      i_por <= por;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      i_por <= 1'b0;
      exp_lock = LOCK_RESET;
      if (por)
      begin
         foreach (exp_in[i]) exp_in[i] = IN_DEF[i*FIELD_W+:FIELD_W];
         foreach (exp_out[i]) exp_out[i] = OUT_SEL_RESET;
      end
   endtask

   // Random writes to every selector; only taken while unlocked
   task automatic fill();
      logic [7:0] d;
      foreach (exp_in[i])
      begin
         d = 8'($urandom);
         wb(1'b1, in_adr(i), d, q);
         if (!exp_lock) exp_in[i] = d[FIELD_W-1:0];
      end
      foreach (exp_out[i])
      begin
         d = 8'($urandom);
         wb(1'b1, out_adr(i), d, q);
         if (!exp_lock) exp_out[i] = d[FIELD_W-1:0];
      end
   endtask

   // Read back everything and compare registers and crossbar ports
   task automatic check_all();
      wb(1'b0, LOCK_ADR, 8'h00, q);
      chk("lock_reg", 32'(exp_lock), q);
      chk("lock_flag", 32'(exp_lock), 32'(o_selection_lock_flag));
      foreach (exp_in[i])
      begin
         wb(1'b0, in_adr(i), 8'h00, q);
         chk("in_reg", 32'(exp_in[i]), q);
         chk("in_port", 32'(exp_in[i]), 32'(o_in_sel[i*FIELD_W+:FIELD_W]));
      end
      foreach (exp_out[i])
      begin
         wb(1'b0, out_adr(i), 8'h00, q);
         chk("out_reg", 32'(exp_out[i]), q);
         chk("out_port", 32'(exp_out[i]), 32'(o_out_sel[i*FIELD_W+:FIELD_W]));
      end
   endtask

   // Key sequence then the lock write; one-shot refuses a later clear
   task automatic key(input logic [7:0] d);
      wb(1'b1, LOCK_ADR, KEY_FIRST, q);
      wb(1'b1, LOCK_ADR, KEY_SECOND, q);
      wb(1'b1, LOCK_ADR, d, q);
      if (!(i_one_shot_lock_config && exp_lock && !d[0])) exp_lock = d[0];
   endtask

   // Watchdog, far beyond the few thousand cycles the sequence needs
   initial
   begin
      #(40 * 30000);
      n_errors++;
      close_out();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'hD54991CF));
      rst(1'b1);
      check_all();
      fill();
      check_all();
      // A write with byte lane 0 disabled must leave the selector alone
      wb(1'b1, out_adr(2), 8'(~exp_out[2]), q, 4'hE);
      wb(1'b0, out_adr(2), 8'h00, q);
      chk("lane_off", 32'(exp_out[2]), q);
      wb(1'b1, LOCK_ADR, 8'hFF, q);
      wb(1'b1, LOCK_ADR, KEY_FIRST, q);
      wb(1'b1, in_adr(3), 8'h05, q);
      exp_in[3] = 5'h05;
      wb(1'b1, LOCK_ADR, KEY_SECOND, q);
      wb(1'b1, LOCK_ADR, 8'h01, q);
      check_all();
      key(8'hFF);
      check_all();
      fill();
      check_all();
      key(8'h00);
      fill();
      check_all();
      rst(1'b0);
      check_all();
      i_one_shot_lock_config <= 1'b1;
      key(8'h01);
      key(8'h00);
      fill();
      check_all();
      // An unmapped place reads zero after a write to it; a misaligned place reads zero
      wb(1'b1, 12'hFFC, 8'hFF, q);
      wb(1'b0, 12'hFFC, 8'h00, q);
      chk("unmapped", READ_ZERO, q);
      wb(1'b0, IN_BASE_ADR + 12'h001, 8'h00, q);
      chk("misaligned", READ_ZERO, q);
      rst(1'b1);
      i_one_shot_lock_config <= 1'b0;
      check_all();
      close_out();
   end
endmodule
